//--- drive_setpoint_mode_control.sv
`timescale 1ns/1ps
`include "dsmc_defs.svh"
// Mode selection, cyclic setpoint latching and step/direction counting.
module drive_setpoint_mode_control (
    input  wire logic        mclk,
    input  wire logic        reset,
    input  wire logic [7:0]  modeSel,
    input  wire logic [3:0]  modeCodingSwitch,
    input  wire logic [15:0] controlWord,
    input  wire logic [15:0] cyclePeriod,
    input  wire logic [7:0]  timeIndex,
    input  wire logic        busSync,
    input  wire logic [31:0] targetVelocity,
    input  wire logic        velocityWrite,
    input  wire logic [31:0] targetTorque,
    input  wire logic        torqueWrite,
    input  wire logic        stepClock,
    input  wire logic        stepDir,
    input  wire logic        pulsePlusDirectionSubmode,
    input  wire logic [15:0] stepNum,
    input  wire logic [15:0] stepDen,
    input  wire logic        closedLoop,
    input  wire logic [31:0] actualPosition,
    input  wire logic [31:0] ferrWindow,
    input  wire logic [15:0] ferrTimeoutMs,
    input  wire logic        limitNeg,
    input  wire logic        limitPos,
    output logic [1:0]       activeMode,
    output logic [15:0]      statusWord,
    output logic [31:0]      velocityCmd,
    output logic [31:0]      torqueCmd,
    output logic [31:0]      demandPosition,
    output logic             cycleTick,
    output logic             limitStop
);
    typedef struct packed {
        dsmc_pkg::dsmc_mode_t mode;
        logic [15:0]          msCnt;
        logic [15:0]          cycCnt;
        logic                 cycTick;
        logic                 velPend;
        logic                 trqPend;
        logic [31:0]          velHold;
        logic [31:0]          trqHold;
        logic [31:0]          velCmd;
        logic [31:0]          trqCmd;
        logic                 clkPrev;
        logic                 dirPrev;
        logic [31:0]          accum;
        logic [31:0]          position;
        logic [15:0]          ferrMs;
        logic                 ferr;
        logic [15:0]          status;
        logic                 limStop;
    } dsmc_state_t;

    dsmc_state_t state_ff;
    dsmc_state_t nxt_state;
    logic        clkSync;
    logic        dirSync;
    logic        msTick;
    logic        stepEvt;
    logic        stepUp;
    logic [31:0] stepInc;
    logic [31:0] sum;
    logic [31:0] err;
    logic [31:0] absErr;
    logic        cyclic;
    logic        validIdx;

    // The step lines come from another party's clock, so they are sampled.
    dsmc_sync u_clkSync (
        .mclk  (mclk),
        .reset (reset),
        .din   (stepClock),
        .dout  (clkSync)
    );
    dsmc_sync u_dirSync (
        .mclk  (mclk),
        .reset (reset),
        .din   (stepDir),
        .dout  (dirSync)
    );

    always_comb begin
        nxt_state = state_ff;
        // Mode decode; the coding switch overrides the software selection.
        if (modeCodingSwitch == `DSMC_SW_PULSE) begin
            nxt_state.mode = dsmc_pkg::DSMC_PULSE;
        end else if (modeSel == `DSMC_MODE_CSV) begin
            nxt_state.mode = dsmc_pkg::DSMC_VEL;
        end else if (modeSel == `DSMC_MODE_CST) begin
            nxt_state.mode = dsmc_pkg::DSMC_TRQ;
        end else if (modeSel == `DSMC_MODE_PULSE) begin
            nxt_state.mode = dsmc_pkg::DSMC_PULSE;
        end else begin
            nxt_state.mode = dsmc_pkg::DSMC_IDLE;
        end

        // Millisecond time base and the cycle built from it.
        validIdx = (timeIndex == `DSMC_TIME_INDEX_MS);
        msTick = 1'b0;
        nxt_state.cycTick = 1'b0;
        if (state_ff.msCnt == 16'(`DSMC_CYC_PER_MS - 1)) begin
            nxt_state.msCnt = 16'h0000;
            msTick = 1'b1;
        end else begin
            nxt_state.msCnt = state_ff.msCnt + 16'h0001;
        end
        if (msTick && validIdx && cyclePeriod != 16'h0000) begin
            if (state_ff.cycCnt + 16'h0001 >= cyclePeriod) begin
                nxt_state.cycCnt = 16'h0000;
                nxt_state.cycTick = 1'b1;
            end else begin
                nxt_state.cycCnt = state_ff.cycCnt + 16'h0001;
            end
        end

        // Setpoints are held until the boundary; a write there is kept.
        if (velocityWrite) begin
            nxt_state.velHold = targetVelocity;
            nxt_state.velPend = 1'b1;
        end
        if (torqueWrite) begin
            nxt_state.trqHold = targetTorque;
            nxt_state.trqPend = 1'b1;
        end
        if (state_ff.cycTick) begin
            // Direct application, no ramp, control word not consulted.
            nxt_state.velCmd = state_ff.velHold;
            nxt_state.trqCmd = state_ff.trqHold;
            nxt_state.velPend = velocityWrite;
            nxt_state.trqPend = torqueWrite;
        end

        // Step decode for both submodes.
        nxt_state.clkPrev = clkSync;
        nxt_state.dirPrev = dirSync;
        if (pulsePlusDirectionSubmode == `DSMC_SUB_TR) begin
            stepEvt = clkSync && !state_ff.clkPrev;
            stepUp = dirSync;
        end else begin
            // Dual line: clock line steps forward, direction line back.
            stepEvt = (clkSync && !state_ff.clkPrev)
                ^ (dirSync && !state_ff.dirPrev);
            stepUp = clkSync && !state_ff.clkPrev;
        end
        // In pulse mode each step adds stepNum, in units of 1/512 full step, to the accumulator, or subtracts it for a backward step.
        stepInc = {16'h0000, stepNum};
        sum = 32'h0000_0000;
        if (state_ff.mode == dsmc_pkg::DSMC_PULSE && stepEvt) begin
            sum = stepUp ? state_ff.accum + stepInc
                         : state_ff.accum - stepInc;
            nxt_state.accum = sum;
        end
        // Signed, so that travel below zero scales correctly; refreshed
        // every cycle, so that a new denominator shows without a step.
        nxt_state.position = (stepDen == 16'h0000) ? nxt_state.accum
            : 32'($signed(nxt_state.accum)
            / $signed({16'h0000, stepDen}));

        // Following error timing in closed loop pulse operation.
        err = state_ff.position - actualPosition;
        absErr = err[31] ? (32'h0000_0000 - err) : err;
        if (state_ff.mode == dsmc_pkg::DSMC_PULSE && closedLoop
            && absErr > ferrWindow) begin
            if (msTick && state_ff.ferrMs != 16'hFFFF) begin
                nxt_state.ferrMs = state_ff.ferrMs + 16'h0001;
            end
            if (state_ff.ferrMs > ferrTimeoutMs) begin
                nxt_state.ferr = 1'b1;
            end
        end else begin
            nxt_state.ferrMs = 16'h0000;
            nxt_state.ferr = 1'b0;
        end

        // Limit switches are honoured in every mode.
        nxt_state.limStop = limitNeg | limitPos;

        cyclic = (state_ff.mode == dsmc_pkg::DSMC_VEL)
            || (state_ff.mode == dsmc_pkg::DSMC_TRQ);
        nxt_state.status = 16'h0000;
        nxt_state.status[`DSMC_ST_SYNC] = cyclic && busSync;
        nxt_state.status[`DSMC_ST_FOLLOW] = cyclic && busSync
            && validIdx && !state_ff.limStop;
        nxt_state.status[`DSMC_ST_ILIM] = state_ff.limStop;
        nxt_state.status[`DSMC_ST_FERR] = state_ff.ferr;
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign activeMode = state_ff.mode;
    assign statusWord = state_ff.status;
    assign velocityCmd = state_ff.velCmd;
    assign torqueCmd = state_ff.trqCmd;
    assign demandPosition = state_ff.position;
    assign cycleTick = state_ff.cycTick;
    assign limitStop = state_ff.limStop;
endmodule

//--- dsmc_defs.svh
`ifndef DSMC_DEFS_SVH
`define DSMC_DEFS_SVH
`define DSMC_MODE_CSV        8'h09
`define DSMC_MODE_CST        8'h0A
`define DSMC_MODE_PULSE      8'hFF
`define DSMC_TIME_INDEX_MS   8'hFD
`define DSMC_CLK_HZ          10_000_000
`define DSMC_BASE_MS         1
`define DSMC_CYC_PER_MS      ((`DSMC_CLK_HZ / 1000) * `DSMC_BASE_MS)
`define DSMC_ST_SYNC         8
`define DSMC_ST_ILIM         11
`define DSMC_ST_FOLLOW       12
`define DSMC_ST_FERR         13
`define DSMC_NUM_RESET       16'h0080
`define DSMC_DEN_RESET       16'h0001
`define DSMC_FULL_STEP       16'h0200
`define DSMC_STEPS_PER_PP    4
`define DSMC_SW_PULSE        4'h1
`define DSMC_SUB_TR          1'b0
`define DSMC_SUB_DUAL        1'b1
`define DSMC_STEP_MAX_HZ     1_000_000
`define DSMC_STEP_MIN_ON_NS  200
`define DSMC_DIR_SETTLE_US   35
`endif

//--- dsmc_pkg.sv
package dsmc_pkg;
    typedef enum logic [1:0] {
        DSMC_IDLE  = 2'b00,
        DSMC_VEL   = 2'b01,
        DSMC_TRQ   = 2'b11,
        DSMC_PULSE = 2'b10
    } dsmc_mode_t;
endpackage

//--- dsmc_sync.sv
`timescale 1ns/1ps
// Two flip-flop synchroniser; the first stage feeds only the second.
module dsmc_sync (
    input  wire logic mclk,
    input  wire logic reset,
    input  wire logic din,
    output logic      dout
);
    typedef struct packed {
        logic s1;
        logic s2;
    } dsmc_sync_t;
    dsmc_sync_t state_ff;
    dsmc_sync_t nxt_state;
    always_comb begin
        nxt_state.s1 = din;
        nxt_state.s2 = state_ff.s1;
    end
    always_ff @(posedge mclk) begin
        if (reset) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end
    assign dout = state_ff.s2;
endmodule

//--- dsmc_props.sv
`timescale 1ns/1ps
module dsmc_props (
    input wire logic        mclk,
    input wire logic        reset,
    input wire logic [7:0]  modeSel,
    input wire logic [3:0]  modeCodingSwitch,
    input wire logic        busSync,
    input wire logic [7:0]  timeIndex,
    input wire logic        closedLoop,
    input wire logic [1:0]  activeMode,
    input wire logic [15:0] statusWord,
    input wire logic [31:0] velocityCmd,
    input wire logic [31:0] torqueCmd,
    input wire logic        cycleTick
);
    default clocking
        @(posedge mclk);
    endclocking
    default disable iff (reset);
    logic sw;
    logic cyc;
    assign sw  = modeCodingSwitch == 4'h1;
    assign cyc = !sw && (modeSel == 8'h09 || modeSel == 8'h0A);
    mode_vel_a: assert property (!sw && modeSel == 8'h09 |=>
        activeMode == dsmc_pkg::DSMC_VEL) else $error("mode not velocity");
    mode_trq_a: assert property (!sw && modeSel == 8'h0A |=>
        activeMode == dsmc_pkg::DSMC_TRQ) else $error("mode not torque");
    mode_pulse_a: assert property (sw || modeSel == 8'hFF |=>
        activeMode == dsmc_pkg::DSMC_PULSE) else $error("mode not pulse");
    mode_idle_a: assert property (!sw && modeSel == 8'h00 |=>
        activeMode == dsmc_pkg::DSMC_IDLE) else $error("mode not idle");
    sync_set_a: assert property ((cyc && busSync)[*3] |=>
        statusWord[8]) else $error("sync bit low");
    sync_clear_a: assert property ((cyc && !busSync)[*3] |=>
        !statusWord[8]) else $error("sync bit high");
    idx_refuse_a: assert property ((timeIndex != 8'hFD)[*3] |->
        !cycleTick) else $error("tick with bad index");
    cmd_hold_a: assert property (!cycleTick |=>
        $stable(velocityCmd) && $stable(torqueCmd))
        else $error("command moved off boundary");
    ferr_open_a: assert property (!closedLoop[*3] |->
        !statusWord[13]) else $error("following error open loop");
    cover property (cycleTick);
    cover property (statusWord[13]);
    cover property (activeMode == dsmc_pkg::DSMC_PULSE);
endmodule

bind drive_setpoint_mode_control dsmc_props u_dsmc_props (
    .mclk, .reset, .modeSel, .modeCodingSwitch, .busSync, .timeIndex,
    .closedLoop, .activeMode, .statusWord, .velocityCmd, .torqueCmd,
    .cycleTick);

//--- dsmc_pulse_source.sv
`timescale 1ns/1ps
// Step source; the clock line rests low, the direction line holds its last level, and nothing toggles between bursts.
module dsmc_pulse_source (
    output logic stepClock,
    output logic stepDir
);
    initial begin
        stepClock = 1'b0;
        stepDir   = 1'b0;
    end
    // In dual mode the direction line carries the negative pulses.
    task automatic burst(input logic neg, input int n, input logic dual);
        if (dual) begin
            stepDir = 1'b0;
        end else if (stepDir !== neg) begin
            stepDir = neg;
            #36000;
        end
        // One 800 ns link period high, one low: 625 kHz.
        repeat (n) begin
            if (dual && neg) stepDir = 1'b1;
            else stepClock = 1'b1;
            #800;
            stepClock = 1'b0;
            if (dual) stepDir = 1'b0;
            #800;
        end
    endtask
endmodule

//--- test_drive_setpoint_mode_control.sv
`timescale 1ns/1ps
module test_drive_setpoint_mode_control;
    logic        mclk = 1'b0;
    logic        reset = 1'b1;
    logic [7:0]  modeSel = 8'h00;
    logic [3:0]  modeCodingSwitch = 4'h0;
    logic [15:0] controlWord = 16'h0000;
    logic [7:0]  timeIndex = 8'h00;
    logic        busSync = 1'b0;
    logic [31:0] target = 32'h0000_0000;
    logic        velocityWrite = 1'b0;
    logic        torqueWrite = 1'b0;
    logic        sub = 1'b0;
    logic [15:0] stepNum = 16'h0080;
    logic [15:0] stepDen = 16'h0001;
    logic        closedLoop = 1'b0;
    logic [31:0] actualPosition = 32'h0000_0000;
    logic        limitNeg = 1'b0;
    logic        limitStop;
    logic [1:0]  activeMode;
    logic [15:0] statusWord;
    logic [31:0] velocityCmd;
    logic [31:0] torqueCmd;
    logic [31:0] demandPosition;
    logic        cycleTick;
    logic        stepClock;
    logic        stepDir;
    logic [31:0] seed = 32'hab23_4d6a;
    int          miscompares = 0;
    int          n_compared = 0;
    drive_setpoint_mode_control u_drive_setpoint_mode_control (
        .mclk, .reset, .modeSel, .modeCodingSwitch, .controlWord,
        .cyclePeriod(16'h0001), .timeIndex, .busSync,
        .targetVelocity(target), .velocityWrite,
        .targetTorque(target), .torqueWrite, .stepClock, .stepDir,
        .pulsePlusDirectionSubmode(sub), .stepNum, .stepDen,
        .closedLoop, .actualPosition, .ferrWindow(32'h0000_0000),
        .ferrTimeoutMs(16'h0001), .limitNeg, .limitPos(1'b0),
        .activeMode, .statusWord, .velocityCmd, .torqueCmd,
        .demandPosition, .cycleTick, .limitStop);
    dsmc_pulse_source u_dsmc_pulse_source (.stepClock, .stepDir);
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input string what, input logic [31:0] e,
                       input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            miscompares++;
            $display("Error %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic complete_run();
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic waitTick();
        int i;
        for (i = 0; i < 12000 && cycleTick !== 1'b1; i++) #100;
        if (i == 12000) begin
            miscompares++;
            complete_run();
        end
    endtask
    initial begin
        forever #50 mclk = ~mclk;
    end
    initial begin
        logic [31:0] last;
        logic [31:0] p0;
        logic [31:0] d;
        int k;
        int n;
        int den;
        repeat (10) @(posedge mclk);
        reset <= 1'b0;
        repeat (300) @(posedge mclk);
        timeIndex <= 8'hFD;
        for (k = 0; k < 2; k++) begin
            modeSel <= k[0] ? 8'h0A : 8'h09;
            busSync <= k[0];
            #1 waitTick();
            // The supervisor writes back to back, every cycle.
            repeat (50) begin
                d = rnd();
                @(posedge mclk);
                target <= d;
                controlWord <= d[15:0];
                velocityWrite <= !k[0];
                torqueWrite <= k[0];
                last = d;
            end
            @(posedge mclk);
            velocityWrite <= 1'b0;
            torqueWrite <= 1'b0;
            #1 waitTick();
            #100 chk("command", last, k[0] ? torqueCmd : velocityCmd);
            chk("sync", 32'(k[0]), 32'(statusWord[8]));
        end
        u_dsmc_pulse_source.burst(1'b0, 4, 1'b0);
        chk("ignored", 32'h0000_0000, demandPosition);
        for (k = 0; k < 4; k++) begin
            d = rnd();
            n = 5 + int'(d[3:0]);
            den = int'(d[5:4]) % 3;
            @(posedge mclk);
            stepNum <= 16'h0080 << (k % 3);
            stepDen <= 16'(den);
            modeSel <= k[0] ? 8'h09 : 8'hFF;
            modeCodingSwitch <= k[0] ? 4'h1 : 4'h0;
            sub <= k[1];
            repeat (3) @(posedge mclk);
            #1 chk("mode", 32'(dsmc_pkg::DSMC_PULSE), 32'(activeMode));
            p0 = demandPosition;
            u_dsmc_pulse_source.burst(1'b0, n, k[1]);
            d = demandPosition - p0;
            if (!k[1] && d[31]) d = -d;
            chk("steps", 32'((n * (128 << (k % 3))) / (den ? den : 1)), d);
            u_dsmc_pulse_source.burst(1'b1, n, k[1]);
            chk("return", p0, demandPosition);
        end
        @(posedge mclk);
        closedLoop <= 1'b1;
        actualPosition <= demandPosition + 32'h0000_1000;
        #1;
        for (k = 0; k < 40000 && statusWord[13] !== 1'b1; k++) #100;
        chk("following error", 32'h0000_0001, 32'(statusWord[13]));
        @(posedge mclk);
        limitNeg <= 1'b1;
        repeat (2) @(posedge mclk);
        #1 chk("limit", 32'h0000_0001, 32'(limitStop));
        complete_run();
    end
endmodule
